/* pkg/mams_pkg.sv */
// Constants for the alarm mask and status-flag block.
// Assumes a 16-bit register port with byte-wide addresses.
package mams_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0]  CTRL_ADDR   = 8'h4E;
    localparam logic [7:0]  STATUS_ADDR = 8'h4F;
    localparam logic [15:0] CTRL_RESET  = 16'h0000;
    localparam logic [15:0] STAT_RESET  = 16'h0000;
    localparam logic [15:0] CTRL_WMASK  = 16'h7FFC;
    localparam logic [15:0] STAT_USED   = 16'h7FFC;
    localparam logic [15:0] PIN_MASKED  = 16'h7FF8;

    // ************************************************************
    // Field positions, shared by control and status except at bit 2
    // ************************************************************
    localparam int IN_ZERO_BIT    = 14;
    localparam int LOC_UNDER_BIT  = 10;
    localparam int LOC_OVER_BIT   = 9;
    localparam int R1_UNDER_BIT   = 8;
    localparam int R1_OVER_BIT    = 7;
    localparam int R2_UNDER_BIT   = 6;
    localparam int R2_OVER_BIT    = 5;
    localparam int R1_FAULT_BIT   = 4;
    localparam int R2_FAULT_BIT   = 3;
    localparam int HOLD_DIS_BIT   = 2;
    localparam int OVERHEAT_BIT   = 2;

    // ************************************************************
    // Die overheat trip, and input-sample persistence
    // ************************************************************
    localparam logic signed [9:0] HOT_TRIP_C = 10'sd150;
    localparam logic signed [9:0] HOT_HYST_C = 10'sd8;
    localparam logic signed [9:0] HOT_FREE_C = HOT_TRIP_C - HOT_HYST_C;
    localparam logic [2:0]  PERSIST_RESET    = 3'h3;
    localparam int          PERSIST_W        = 9;

endpackage

/* hdl/mams_alarm_status.sv */
// Alarm masking, status flags and active-low alarm output.
// Assumes range decisions and sample strobes arrive synchronous to clk_i
// from the converter and sensor logic; register port is single-cycle.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Control bit 7 lets remote one over-range pull the alarm low.
// - Control bit 6 lets remote two under-range pull the alarm low.
// - Control bit 5 lets remote two over-range pull the alarm low.
// - Control bit 4 lets remote one fault pull the alarm low.
// - Control bit 3 lets remote two fault pull the alarm low.
// - Hold mode: flag stays until condition gone and status read.
// - Hold disabled: flags follow the live condition.
// - Status bit 14 flags input zero out of range.
// - Status bit 13 flags input one out of range.
// - Status bit 12 flags input two out of range.
// - Status bit 11 flags input three out of range.
// - Status bit 10 flags local under-range, only when enabled.
// - Status bit 9 flags local over-range, only when enabled.
// - Status bit 8 flags remote one under-range, only when enabled.
// - Status is read-only at 0x4F, resets zero, reserved bits zero.
// - Bits 7, 6, 5 flag remote one over, remote two under/over.
// - Bits 4 and 3 flag open or short on remote one and two.
// - Bit 2 flags die at or above 150 C, 8 C hysteresis.
// - Input alarms need a programmed count of consecutive bad samples.
module mams_alarm_status #(
    parameter int NUM_IN = 4
) (
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    input  wire logic [15:0]       reg_wdata_i,
    output logic      [15:0]       reg_rdata_o,
    output logic                   reg_rvalid_o,
    input  wire logic [NUM_IN-1:0] ch_sample_i,
    input  wire logic [NUM_IN-1:0] ch_out_range_i,
    input  wire logic [2:0]        input_persist_count_i,
    input  wire logic              local_sensor_enable_i,
    input  wire logic              remote_one_sensor_enable_i,
    input  wire logic              remote_two_sensor_enable_i,
    input  wire logic              local_under_i,
    input  wire logic              local_over_i,
    input  wire logic              remote_one_under_i,
    input  wire logic              remote_one_over_i,
    input  wire logic              remote_one_fault_i,
    input  wire logic              remote_two_under_i,
    input  wire logic              remote_two_over_i,
    input  wire logic              remote_two_fault_i,
    input  wire logic signed [9:0] die_temp_i,
    input  wire logic              alarm_pin_enable_i,
    output logic                   alarm_n_o
);

    // ************************************************************
    // Register port decode
    // ************************************************************
    logic        wr_ctrl;
    logic        rd_stat;
    logic        rd_ctrl;
    logic        flag_hold_disable;
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic [15:0] rdata_d;

    // Writes to status or unmapped addresses are dropped
    assign wr_ctrl = reg_wr_i && (reg_addr_i == mams_pkg::CTRL_ADDR);
    assign rd_stat = reg_rd_i && (reg_addr_i == mams_pkg::STATUS_ADDR);
    assign rd_ctrl = reg_rd_i && (reg_addr_i == mams_pkg::CTRL_ADDR);
    assign flag_hold_disable = ctrl_q[mams_pkg::HOLD_DIS_BIT];

    // ************************************************************
    // Consecutive-sample filter for the input channels
    // ************************************************************
    logic [mams_pkg::PERSIST_W-1:0] persist_thr;
    logic [NUM_IN-1:0]              ch_cond;

    // Code 0 means one sample, code n otherwise means 2^(n+1)
    always_comb begin
        if (input_persist_count_i == 3'h0) begin
            persist_thr = 9'h001;
        end else begin
            // Four-bit sum, so code 7 reaches 256 instead of wrapping
            persist_thr = 9'h001 << ({1'b0, input_persist_count_i} + 4'h1);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_in
            logic [mams_pkg::PERSIST_W-1:0] run_q;
            logic [mams_pkg::PERSIST_W-1:0] run_d;

            // Saturating run length of bad samples; a good one restarts it
            always_comb begin
                run_d = run_q;
                if (ch_sample_i[gi]) begin
                    if (!ch_out_range_i[gi]) begin
                        run_d = '0;
                    end else if (run_q != 9'h1FF) begin
                        run_d = run_q + 9'h001;
                    end
                end
            end

            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    run_q <= '0;
                end else begin
                    run_q <= run_d;
                end
            end

            assign ch_cond[gi] = (run_q >= persist_thr);
        end
    endgenerate

    // ************************************************************
    // Die overheat detector with hysteresis
    // ************************************************************
    logic hot_q;
    logic hot_d;

    // Holds until the die drops below trip minus hysteresis or the local sensor is disabled
    always_comb begin
        hot_d = 1'b0;
        if (local_sensor_enable_i) begin
            hot_d = (die_temp_i >= mams_pkg::HOT_TRIP_C) ||
                    (hot_q && (die_temp_i >= mams_pkg::HOT_FREE_C));
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hot_q <= 1'b0;
        end else begin
            hot_q <= hot_d;
        end
    end

    // ************************************************************
    // Live condition vector, in status bit order
    // ************************************************************
    logic [15:0] cond_w;

    // Sensor checks are masked off while the sensor is disabled
    always_comb begin
        cond_w = 16'h0000;
        cond_w[14] = ch_cond[0];
        cond_w[13] = ch_cond[1];
        cond_w[12] = ch_cond[2];
        cond_w[11] = ch_cond[3];
        cond_w[mams_pkg::LOC_UNDER_BIT] =
            local_sensor_enable_i && local_under_i;
        cond_w[mams_pkg::LOC_OVER_BIT] =
            local_sensor_enable_i && local_over_i;
        cond_w[mams_pkg::R1_UNDER_BIT] =
            remote_one_sensor_enable_i && remote_one_under_i;
        cond_w[mams_pkg::R1_OVER_BIT] =
            remote_one_sensor_enable_i && remote_one_over_i;
        cond_w[mams_pkg::R2_UNDER_BIT] =
            remote_two_sensor_enable_i && remote_two_under_i;
        cond_w[mams_pkg::R2_OVER_BIT] =
            remote_two_sensor_enable_i && remote_two_over_i;
        cond_w[mams_pkg::R1_FAULT_BIT] =
            remote_one_sensor_enable_i && remote_one_fault_i;
        cond_w[mams_pkg::R2_FAULT_BIT] =
            remote_two_sensor_enable_i && remote_two_fault_i;
        cond_w[mams_pkg::OVERHEAT_BIT] = hot_q;
    end

    // ************************************************************
    // Status flags and read tracking
    // ************************************************************
    logic [15:0] flag_q;
    logic [15:0] flag_d;
    logic [15:0] seen_q;
    logic [15:0] seen_d;
    logic        alarm_n_d;

    // In hold mode a bit only clears once read and gone; a new set beats the clear
    always_comb begin
        if (flag_hold_disable) begin
            flag_d = cond_w & mams_pkg::STAT_USED;
        end else begin
            flag_d = (cond_w | (flag_q & ~(seen_q & ~cond_w)))
                     & mams_pkg::STAT_USED;
        end
        // Seen marks drop with their flag, so a re-set needs a new read
        seen_d = (seen_q | (rd_stat ? flag_q : 16'h0000)) & flag_d;
    end

    // Control writes and registered read data
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = reg_wdata_i & mams_pkg::CTRL_WMASK;
        end
        rdata_d = 16'h0000;
        if (rd_stat) begin
            rdata_d = flag_q;
        end else if (rd_ctrl) begin
            rdata_d = ctrl_q;
        end
    end

    // Pin uses last cycle's flags so it stays glitch free off a flop
    always_comb begin
        alarm_n_d = !(alarm_pin_enable_i &&
                      (|(flag_q & ctrl_q & mams_pkg::PIN_MASKED)));
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flag_q       <= mams_pkg::STAT_RESET;
            seen_q       <= 16'h0000;
            ctrl_q       <= mams_pkg::CTRL_RESET;
            reg_rdata_o  <= 16'h0000;
            reg_rvalid_o <= 1'b0;
            alarm_n_o    <= 1'b1;
        end else begin
            flag_q       <= flag_d;
            seen_q       <= seen_d;
            ctrl_q       <= ctrl_d;
            reg_rdata_o  <= rdata_d;
            reg_rvalid_o <= reg_rd_i;
            alarm_n_o    <= alarm_n_d;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    unlatch_follow_a: assert property (@(posedge clk_i) disable iff (reset_i)
        flag_hold_disable |=> (flag_q == $past(cond_w & 16'h7FFC)))
        else $error("live flags do not follow condition");

    latch_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !flag_hold_disable |=>
        (($past(flag_q) & ~$past(seen_q) & ~flag_q) == 16'h0000))
        else $error("held flag cleared without a read");

    latch_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !flag_hold_disable |=>
        ((flag_q & $past(cond_w)) == $past(cond_w & 16'h7FFC)))
        else $error("present condition not flagged");

    read_data_a: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_stat |=> (reg_rvalid_o && (reg_rdata_o == $past(flag_q))))
        else $error("status read returned wrong value");

    reserved_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (flag_q & 16'h8003) == 16'h0000)
        else $error("reserved status bit set");

    alarm_pin_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (alarm_pin_enable_i && (|(flag_q & ctrl_q & 16'h7FF8)))
        |=> !alarm_n_o ##1 1'b1)
        else $error("alarm pin not driven low");

    alarm_mask_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (!(|(flag_q & ctrl_q & 16'h7FF8))) |=> alarm_n_o)
        else $error("masked flag drove alarm pin");

    therm_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !local_sensor_enable_i |=> !hot_q)
        else $error("overheat set with local sensor off");

    therm_hyst_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (hot_q && local_sensor_enable_i && (die_temp_i >= 10'sd142))
        |=> hot_q)
        else $error("overheat dropped inside hysteresis");

    persist_reset_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (ch_sample_i[0] && !ch_out_range_i[0]) |=> !cond_w[14])
        else $error("input alarm survived good sample");

    local_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !local_sensor_enable_i |-> (cond_w[10:9] == 2'b00))
        else $error("local check active while disabled");

    read_clear_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !flag_hold_disable |=> ((flag_q & $past(seen_q & ~cond_w)) == 16'h0000))
        else $error("read flag kept after condition gone");

    persist_top_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (input_persist_count_i == 3'h7) |-> (persist_thr == 9'h100))
        else $error("longest sample count not decoded");

    input_flag_c: cover property (@(posedge clk_i) disable iff (reset_i)
        !flag_q[14] ##1 flag_q[14]);

    held_alarm_c: cover property (@(posedge clk_i) disable iff (reset_i)
        !flag_hold_disable && flag_q[14] ##1 rd_stat ##[1:20] !flag_q[14]);

    pin_low_c: cover property (@(posedge clk_i) disable iff (reset_i)
        alarm_n_o ##1 !alarm_n_o);

    overheat_c: cover property (@(posedge clk_i) disable iff (reset_i)
        !hot_q ##1 hot_q);

endmodule

`default_nettype wire

/* sim/mams_host_model.sv */
// Host model: register master of the block; the bench watches its alarm pin.
// Assumes one clock; requests move 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module mams_host_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] reg_rdata_i,
    input  wire logic        reg_rvalid_i,
    output logic      [7:0]  reg_addr_o,
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    output logic      [15:0] reg_wdata_o
);
    // Idle data never repeats the last word written
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_wdata_o = 16'h5A5A;
    end
    // Strobe held across exactly one taken edge
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i) #1;
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = 1'b1;
        @(posedge clk_i) #1;
        reg_wr_o    = 1'b0;
        reg_wdata_o = ~d;
    endtask
    // Bounded wait, so a dead port cannot hang the run
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d,
                          output logic ok);
        @(posedge clk_i) #1;
        reg_addr_o = a;
        reg_rd_o   = 1'b1;
        @(posedge clk_i) #1;
        reg_rd_o   = 1'b0;
        for (int n = 0; n < 4 && reg_rvalid_i !== 1'b1; n++)
            @(posedge clk_i) #1;
        ok = (reg_rvalid_i === 1'b1);
        d  = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

/* sim/mams_alarm_status_tb.sv */
// Bench for the alarm mask and status-flag block, random masks and pin.
// Assumes the host model owns the register port; bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module mams_alarm_status_tb;
    logic              clk_i;
    logic              reset_i = 1'b1;
    logic [7:0]        reg_addr_i;
    logic              reg_wr_i, reg_rd_i, reg_rvalid_o, alarm_n_o, ok;
    logic [15:0]       reg_wdata_i, reg_rdata_o, got, bv, msk;
    logic [3:0]        ch_sample_i = 4'h0;
    logic [3:0]        ch_out_range_i = 4'h0;
    logic [2:0]        input_persist_count_i = 3'h0;
    logic [2:0]        sen = 3'h7;
    logic [7:0]        cond = 8'h00;
    logic signed [9:0] die_temp_i = 10'h019;
    logic              alarm_pin_enable_i = 1'b1;
    logic              live, e;
    logic [31:0]       r;
    int                err_count = 0;
    int                total_checks = 0;
    int                seed = 32'h6760;
    int                k;
    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    mams_alarm_status i_mams_alarm_status (
        .clk_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
        .reg_rdata_o, .reg_rvalid_o, .ch_sample_i, .ch_out_range_i,
        .input_persist_count_i, .local_sensor_enable_i(sen[2]),
        .remote_one_sensor_enable_i(sen[1]),
        .remote_two_sensor_enable_i(sen[0]),
        .local_under_i(cond[7]), .local_over_i(cond[6]),
        .remote_one_under_i(cond[5]), .remote_one_over_i(cond[4]),
        .remote_two_under_i(cond[3]), .remote_two_over_i(cond[2]),
        .remote_one_fault_i(cond[1]), .remote_two_fault_i(cond[0]),
        .die_temp_i, .alarm_pin_enable_i, .alarm_n_o
    );
    mams_host_model i_mams_host_model (
        .clk_i, .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o),
        .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
        .reg_wdata_o(reg_wdata_i)
    );
    // ************************************************************
    // Checking and driving helpers
    // ************************************************************
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] s, x);
        total_checks++;
        if (s !== x) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic do_reset;
        reset_i = 1'b1;
        tick(6);
        reset_i = 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_mams_host_model.wr_reg(a, d);
    endtask
    // A lost read answer ends the run at once
    task automatic rc(input logic [7:0] a, input logic [15:0] x, string nm);
        i_mams_host_model.rd_reg(a, got, ok);
        if (ok !== 1'b1) begin
            check(nm, {15'h0000, ok}, 16'h0001);
            final_report();
        end else begin
            check(nm, got, x);
        end
    endtask
    task automatic cp(input logic x, input string nm);
        check(nm, {15'h0000, alarm_n_o}, {15'h0000, x});
    endtask
    // Expected pin: low only for an enabled, maskable flag with pin on
    function automatic logic pin_exp(input logic [15:0] f, c, input logic p);
        return !(p && ((f & c & 16'h7FF8) != 16'h0000));
    endfunction
    // Which sensor enable gates condition k
    function automatic logic [2:0] grp(input int n);
        return (n >= 6) ? 3'h4 : (n == 5 || n == 4 || n == 1) ? 3'h2 : 3'h1;
    endfunction
    // Bad samples needed before an input flag, per count code
    function automatic int run_len(input int c);
        return (c == 0) ? 1 : (c == 1) ? 4 : (8 << (c - 2));
    endfunction
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        do_reset();
        cp(1'b1, "pin_reset");
        rc(8'h4F, 16'h0000, "status_reset");
        rc(8'h4E, 16'h0000, "control_reset");
        wr(8'h4F, 16'hFFFF);
        wr(8'h4E, 16'hFFFF);
        rc(8'h4F, 16'h0000, "status_ro");
        rc(8'h4E, 16'h7FFC, "control_rw");
        rc(8'h4D, 16'h0000, "unmapped");
        $display("test registers done");
        // Each sensor condition, hold mode first, then live mode
        for (int j = 0; j < 16; j++) begin
            r = $random(seed);
            k = j % 8;
            live = (j >= 8);
            e = live ? r[0] : 1'b1;
            sen = e ? 3'h7 : ~grp(k);
            alarm_pin_enable_i = r[2];
            bv = 16'h0001 << (k + 3);
            msk = (r[1] ? bv : 16'h0000) | (live ? 16'h0004 : 16'h0000);
            wr(8'h4E, msk);
            cond[k] = 1'b1;
            tick(2);
            cp(pin_exp(e ? bv : 16'h0000, msk, r[2]), "pin_set");
            if (live)
                rc(8'h4F, e ? bv : 16'h0000, "flag_live");
            cond[k] = 1'b0;
            tick(3);
            cp(pin_exp(live ? 16'h0000 : bv, msk, r[2]), "pin_after");
            rc(8'h4F, live ? 16'h0000 : bv, "flag_after");
            rc(8'h4F, 16'h0000, "flag_clear");
        end
        $display("test sensors done");
        // Read while the condition is still present
        sen = 3'h7;
        wr(8'h4E, 16'h0000);
        cond[6] = 1'b1;
        rc(8'h4F, 16'h0200, "read_present");
        rc(8'h4F, 16'h0200, "still_present");
        cond[6] = 1'b0;
        rc(8'h4F, 16'h0000, "gone_first");
        rc(8'h4F, 16'h0000, "gone_read");
        $display("test hold done");
        // Input channels with counts of one and four samples
        for (int i = 0; i < 4; i++) begin
            do_reset();
            r = $random(seed);
            input_persist_count_i = 3'(i % 2);
            alarm_pin_enable_i = 1'b1;
            ch_out_range_i = 4'hF;
            msk = r[15:0] & 16'h7800;
            bv = 16'h4000 >> i;
            wr(8'h4E, msk);
            if (i % 2 == 1) begin
                ch_sample_i[i] = 1'b1;
                tick(3);
                ch_sample_i[i] = 1'b0;
                tick(2);
                rc(8'h4F, 16'h0000, "below_count");
            end
            ch_sample_i[i] = 1'b1;
            tick(1);
            ch_sample_i[i] = 1'b0;
            tick(2);
            cp(pin_exp(bv, msk, 1'b1), "pin_input");
            rc(8'h4F, bv, "input_flag");
        end
        // Longer count codes on input zero: one sample short, then enough
        for (int c = 2; c < 8; c++) begin
            do_reset();
            input_persist_count_i = 3'(c);
            ch_sample_i[0] = 1'b1;
            tick(run_len(c) - 1);
            ch_sample_i[0] = 1'b0;
            rc(8'h4F, 16'h0000, "long_short");
            ch_sample_i[0] = 1'b1;
            tick(1);
            ch_sample_i[0] = 1'b0;
            rc(8'h4F, 16'h4000, "long_full");
        end
        $display("test inputs done");
        // Die overheat with hysteresis, never on the pin
        do_reset();
        wr(8'h4E, 16'hFFFF);
        // One spare edge: detector then flag, so a read sees both stages
        die_temp_i = 10'h096;
        tick(1);
        rc(8'h4F, 16'h0004, "hot_set");
        cp(1'b1, "hot_pin");
        die_temp_i = 10'h08E;
        tick(1);
        rc(8'h4F, 16'h0004, "hot_hyst");
        die_temp_i = 10'h08D;
        tick(1);
        rc(8'h4F, 16'h0000, "hot_free");
        die_temp_i = 10'h096;
        sen = 3'h3;
        tick(1);
        rc(8'h4F, 16'h0000, "hot_disabled");
        $display("test overheat done");
        final_report();
    end
endmodule
`default_nettype wire
